// ---- rtl/flash_status_host.sv ----
// Host controller that issues flash command cycles and tracks operation status.
// Assumes software orders it through the plain register port and that the
// flash pins are asynchronous to ref_clk_in.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module flash_status_host #(
	parameter int unsigned ADDR_W = 21
) (
	input  wire logic              ref_clk_in,       // 25 MHz clock
	input  wire logic              rst_b_in,         // Synchronous reset, active low
	input  wire logic              clk_en_in,        // Freezes state while low
	input  wire logic [7:0]        reg_addr_in,      // Register byte address
	input  wire logic [31:0]       reg_wdata_in,     // Register write data
	input  wire logic              reg_wr_in,        // Write strobe
	input  wire logic              reg_rd_in,        // Read strobe
	output logic      [31:0]       reg_rdata_out,    // Read data, cycle after strobe
	output logic      [ADDR_W-1:0] flash_addr_out,   // Flash address pins
	input  wire logic [7:0]        dq_in,            // Data lines as seen
	output logic      [7:0]        dq_out,           // Data lines driven value
	output logic                   dq_oe_out,        // Data lines enable
	output logic                   ce_b_out,         // Chip select, active low
	output logic                   oe_b_out,         // Output enable, active low
	output logic                   we_b_out,         // Write strobe, active low
	input  wire logic              ready_busy_in,    // Ready/busy pin level
	output logic                   flash_reset_b_out, // Flash reset pin, active low
	output logic                   hv_unprotect_out  // Request high voltage on reset pin
);
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h1,
		ST_WAIT   = 3'h2,
		ST_DECIDE = 3'h4
	} seq_state_e;

	seq_state_e        state_q;
	logic [2:0]        op_q;
	logic [2:0]        phase_q;
	logic              abort_q;
	logic              launch_q;
	logic              eng_write_q;
	logic [ADDR_W-1:0] eng_addr_q;
	logic [7:0]        eng_data_q;
	logic [7:0]        samp_a_q;
	logic [7:0]        samp_b_q;
	logic              done_q;
	logic              fail_q;
	logic              reject_q;
	logic              need_reset_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0]        wdata_q;
	logic [7:0]        dq_sync;
	logic [0:0]        ready_sync;
	logic              eng_done;
	logic [7:0]        eng_rdata;
	logic              order_wr;
	logic [2:0]        order_op;
	logic              order_ok;
	logic              toggles_equal;
	logic [31:0]       status_w;

	flash_pin_sync #(.WIDTH(8)) dq_sync_u (
		.ref_clk_in (ref_clk_in),
		.rst_b_in   (rst_b_in),
		.clk_en_in  (clk_en_in),
		.pin_in     (dq_in),
		.sync_out   (dq_sync)
	);

	flash_pin_sync #(.WIDTH(1)) ready_sync_u (
		.ref_clk_in (ref_clk_in),
		.rst_b_in   (rst_b_in),
		.clk_en_in  (clk_en_in),
		.pin_in     (ready_busy_in),
		.sync_out   (ready_sync)
	);

	flash_cycle_engine #(.ADDR_W(ADDR_W)) engine_u (
		.ref_clk_in     (ref_clk_in),
		.rst_b_in       (rst_b_in),
		.clk_en_in      (clk_en_in),
		.start_in       (launch_q),
		.write_in       (eng_write_q),
		.addr_in        (eng_addr_q),
		.data_in        (eng_data_q),
		.sync_data_in   (dq_sync),
		.done_out       (eng_done),
		.rdata_out      (eng_rdata),
		.flash_addr_out (flash_addr_out),
		.dq_out         (dq_out),
		.dq_oe_out      (dq_oe_out),
		.ce_b_out       (ce_b_out),
		.oe_b_out       (oe_b_out),
		.we_b_out       (we_b_out)
	);

	assign order_wr = clk_en_in && reg_wr_in && (reg_addr_in == flash_host_pkg::REG_ORDER);
	assign order_op = reg_wdata_in[2:0];
	// Orders other than abort are refused while a sequence runs
	assign order_ok = order_wr && (state_q == ST_IDLE) && (order_op >= flash_host_pkg::OP_WRITE)
		&& (order_op <= flash_host_pkg::OP_ADD_SECTOR);
	assign toggles_equal = samp_a_q[flash_host_pkg::TOGGLE_POS] ==
		samp_b_q[flash_host_pkg::TOGGLE_POS];

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
		begin
			addr_q            <= '0;
			wdata_q           <= 8'h00;
			hv_unprotect_out  <= 1'b0;
			flash_reset_b_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			// Flash leaves its own reset one cycle after ours
			flash_reset_b_out <= 1'b1;
			if (reg_wr_in && reg_addr_in == flash_host_pkg::REG_ADDR)
				addr_q <= reg_wdata_in[ADDR_W-1:0];
			if (reg_wr_in && reg_addr_in == flash_host_pkg::REG_WDATA)
				wdata_q <= reg_wdata_in[7:0];
			if (reg_wr_in && reg_addr_in == flash_host_pkg::REG_UNPROT)
				hv_unprotect_out <= reg_wdata_in[0];
		end
	end

	always_comb
	begin
		status_w = 32'h0000_0000;
		status_w[flash_host_pkg::ST_BUSY]   = (state_q != ST_IDLE);
		status_w[flash_host_pkg::ST_DONE]   = done_q;
		status_w[flash_host_pkg::ST_FAIL]   = fail_q;
		status_w[flash_host_pkg::ST_REJECT] = reject_q;
		status_w[flash_host_pkg::ST_READY]  = ready_sync[0];
		status_w[flash_host_pkg::ST_DATA +: 8] = samp_b_q;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
			reg_rdata_out <= 32'h0000_0000;
		else if (clk_en_in)
		begin
			reg_rdata_out <= 32'h0000_0000;
			if (reg_rd_in)
			begin
				unique case (reg_addr_in)
					flash_host_pkg::REG_ORDER:  reg_rdata_out <= {29'h0, op_q};
					flash_host_pkg::REG_ADDR:   reg_rdata_out <= 32'(addr_q);
					flash_host_pkg::REG_WDATA:  reg_rdata_out <= {24'h0, wdata_q};
					flash_host_pkg::REG_STATUS: reg_rdata_out <= status_w;
					flash_host_pkg::REG_UNPROT: reg_rdata_out <= {31'h0, hv_unprotect_out};
					default:                    reg_rdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Sample history: each finished read shifts into the pair compared for toggling
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
		begin
			samp_a_q <= 8'h00;
			samp_b_q <= 8'h00;
		end
		else if (clk_en_in && eng_done && !eng_write_q)
		begin
			samp_a_q <= samp_b_q;
			samp_b_q <= eng_rdata;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
		begin
			state_q      <= ST_IDLE;
			op_q         <= 3'h0;
			phase_q      <= flash_host_pkg::PH_FIRST;
			abort_q      <= 1'b0;
			launch_q     <= 1'b0;
			eng_write_q  <= 1'b0;
			eng_addr_q   <= '0;
			eng_data_q   <= 8'h00;
			done_q       <= 1'b0;
			fail_q       <= 1'b0;
			reject_q     <= 1'b0;
			need_reset_q <= 1'b0;
		end
		else if (clk_en_in)
		begin
			launch_q <= 1'b0;
			if (order_wr && order_op == flash_host_pkg::OP_ABORT && state_q != ST_IDLE)
				abort_q <= 1'b1;
			unique case (state_q)
				ST_IDLE:
				begin
					abort_q <= 1'b0;
					if (order_ok)
					begin
						// Polling always begins with a fresh pair of reads
						op_q        <= order_op;
						phase_q     <= flash_host_pkg::PH_FIRST;
						done_q      <= 1'b0;
						fail_q      <= 1'b0;
						reject_q    <= 1'b0;
						eng_write_q <= (order_op == flash_host_pkg::OP_WRITE);
						eng_addr_q  <= addr_q;
						eng_data_q  <= wdata_q;
						launch_q    <= 1'b1;
						state_q     <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					if (eng_done)
					begin
						if (eng_write_q && need_reset_q)
							need_reset_q <= 1'b0;
						state_q <= ST_DECIDE;
					end
				end
				ST_DECIDE:
				begin
					if (abort_q)
					begin
						// Abandoned polling is not resumed mid-way
						abort_q <= 1'b0;
						state_q <= ST_IDLE;
					end
					else if (op_q == flash_host_pkg::OP_POLL)
					begin
						unique case (phase_q)
							flash_host_pkg::PH_FIRST:
							begin
								eng_write_q <= 1'b0;
								launch_q    <= 1'b1;
								phase_q     <= flash_host_pkg::PH_SECOND;
								state_q     <= ST_WAIT;
							end
							flash_host_pkg::PH_SECOND:
							begin
								if (toggles_equal)
								begin
									done_q  <= 1'b1;
									state_q <= ST_IDLE;
								end
								else
								begin
									// Timeout seen: retest, else start a new pair
									eng_write_q <= 1'b0;
									launch_q    <= 1'b1;
									state_q     <= ST_WAIT;
									if (samp_b_q[flash_host_pkg::TIMEOUT_POS])
										phase_q <= flash_host_pkg::PH_THIRD;
									else
										phase_q <= flash_host_pkg::PH_FIRST;
								end
							end
							flash_host_pkg::PH_THIRD:
							begin
								eng_write_q <= 1'b0;
								launch_q    <= 1'b1;
								phase_q     <= flash_host_pkg::PH_FOURTH;
								state_q     <= ST_WAIT;
							end
							flash_host_pkg::PH_FOURTH:
							begin
								if (toggles_equal)
								begin
									done_q  <= 1'b1;
									state_q <= ST_IDLE;
								end
								else
								begin
									// Failed: the reset command goes out first
									fail_q       <= 1'b1;
									need_reset_q <= 1'b1;
									eng_write_q  <= 1'b1;
									eng_data_q   <= flash_host_pkg::RESET_CMD;
									launch_q     <= 1'b1;
									phase_q      <= flash_host_pkg::PH_RESET;
									state_q      <= ST_WAIT;
								end
							end
							default:
							begin
								done_q  <= 1'b1;
								state_q <= ST_IDLE;
							end
						endcase
					end
					else if (op_q == flash_host_pkg::OP_ADD_SECTOR &&
						phase_q != flash_host_pkg::PH_THIRD)
					begin
						// Window flag read before the command, command, then read again
						eng_write_q <= (phase_q == flash_host_pkg::PH_FIRST);
						launch_q    <= 1'b1;
						phase_q     <= phase_q + 3'h1;
						state_q     <= ST_WAIT;
					end
					else
					begin
						if (op_q == flash_host_pkg::OP_ADD_SECTOR)
							reject_q <= samp_b_q[flash_host_pkg::ERASE_WINDOW_POS];
						done_q  <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	poll_equal_done_a: assert property (
		@(posedge ref_clk_in) disable iff (!rst_b_in || !clk_en_in)
		(state_q == ST_DECIDE && op_q == flash_host_pkg::OP_POLL && !abort_q &&
		phase_q == flash_host_pkg::PH_SECOND && toggles_equal)
		|=> (state_q == ST_IDLE && done_q && !fail_q))
		else $error("equal toggle pair did not end polling as complete");

	timeout_retest_a: assert property (
		@(posedge ref_clk_in) disable iff (!rst_b_in || !clk_en_in)
		(state_q == ST_DECIDE && op_q == flash_host_pkg::OP_POLL && !abort_q &&
		phase_q == flash_host_pkg::PH_SECOND && !toggles_equal &&
		samp_b_q[flash_host_pkg::TIMEOUT_POS])
		|=> (launch_q && !eng_write_q && phase_q == flash_host_pkg::PH_THIRD))
		else $error("timeout flag seen but toggle not retested");

	fail_reset_a: assert property (
		@(posedge ref_clk_in) disable iff (!rst_b_in || !clk_en_in)
		(state_q == ST_DECIDE && op_q == flash_host_pkg::OP_POLL && !abort_q &&
		phase_q == flash_host_pkg::PH_FOURTH && !toggles_equal)
		|=> (fail_q && launch_q && eng_write_q) ##1 (eng_data_q == flash_host_pkg::RESET_CMD))
		else $error("failed operation not followed by reset command");

	poll_restart_a: assert property (
		@(posedge ref_clk_in) disable iff (!rst_b_in || !clk_en_in)
		(order_ok && order_op == flash_host_pkg::OP_POLL)
		|=> (launch_q && phase_q == flash_host_pkg::PH_FIRST && !eng_write_q))
		else $error("polling did not restart from the first read");

	reset_first_a: assert property (
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		(launch_q && need_reset_q)
		|-> (eng_write_q && eng_data_q == flash_host_pkg::RESET_CMD))
		else $error("command issued before reset after failure");

	window_check_a: assert property (
		@(posedge ref_clk_in) disable iff (!rst_b_in || !clk_en_in)
		(state_q == ST_DECIDE && op_q == flash_host_pkg::OP_ADD_SECTOR && !abort_q &&
		phase_q == flash_host_pkg::PH_THIRD)
		|=> (reject_q == $past(samp_b_q[flash_host_pkg::ERASE_WINDOW_POS]) && done_q))
		else $error("second erase window check not reported");
endmodule : flash_status_host
`default_nettype wire

// ---- rtl/flash_host_pkg.sv ----
// Constants shared by the flash status-polling host controller.
// Assumes a 25 MHz controller clock; timings are converted to cycles here.
package flash_host_pkg;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned T_ACCESS_NS   = 70;
	localparam int unsigned T_WE_PULSE_NS = 35;
	localparam int unsigned T_RECOVER_NS  = 30;
	localparam int unsigned SYNC_STAGES   = 2;
	// Least times round up to whole cycles
	localparam int unsigned ACCESS_CYC  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WE_CYC      = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  WE_CNT      = 4'(WE_CYC - 1);
	localparam logic [3:0]  READ_CNT    = 4'(ACCESS_CYC + SYNC_STAGES - 1);
	localparam logic [3:0]  RECOVER_CNT = 4'(RECOVER_CYC - 1);

	localparam logic [7:0] REG_ORDER  = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_UNPROT = 8'h10;

	localparam logic [2:0] OP_WRITE      = 3'h1;
	localparam logic [2:0] OP_READ       = 3'h2;
	localparam logic [2:0] OP_POLL       = 3'h3;
	localparam logic [2:0] OP_ADD_SECTOR = 3'h4;
	localparam logic [2:0] OP_ABORT      = 3'h5;

	localparam logic [2:0] PH_FIRST  = 3'h0;
	localparam logic [2:0] PH_SECOND = 3'h1;
	localparam logic [2:0] PH_THIRD  = 3'h2;
	localparam logic [2:0] PH_FOURTH = 3'h3;
	localparam logic [2:0] PH_RESET  = 3'h4;

	// Positions on the data lines
	localparam int unsigned DATA_POLL_POS    = 32'h7;
	localparam int unsigned TOGGLE_POS       = 32'h6;
	localparam int unsigned TIMEOUT_POS      = 32'h5;
	localparam int unsigned ERASE_WINDOW_POS = 32'h3;
	localparam int unsigned SECTOR_TOG_POS   = 32'h2;

	localparam logic [7:0] RESET_CMD = 8'hF0;

	// Status register layout
	localparam int unsigned ST_BUSY   = 32'h0;
	localparam int unsigned ST_DONE   = 32'h1;
	localparam int unsigned ST_FAIL   = 32'h2;
	localparam int unsigned ST_REJECT = 32'h3;
	localparam int unsigned ST_READY  = 32'h4;
	localparam int unsigned ST_DATA   = 32'h8;
endpackage : flash_host_pkg

// ---- rtl/flash_pin_sync.sv ----
// Two-stage synchroniser for pins arriving from the flash device.
// Assumes the inputs are asynchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
module flash_pin_sync #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             ref_clk_in, // Controller clock
	input  wire logic             rst_b_in,   // Synchronous reset, active low
	input  wire logic             clk_en_in,  // Freezes state while low
	input  wire logic [WIDTH-1:0] pin_in,     // Asynchronous pin levels
	output logic      [WIDTH-1:0] sync_out    // Synchronised levels
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else if (clk_en_in)
		begin
			meta_q   <= pin_in;
			sync_out <= meta_q;
		end
	end
endmodule : flash_pin_sync
`default_nettype wire

// ---- rtl/flash_cycle_engine.sv ----
// Drives one asynchronous read or write cycle on the flash strobes.
// Assumes read data arrive through a two-stage synchroniser outside.
`timescale 1ns/1ps
`default_nettype none
module flash_cycle_engine #(
	parameter int unsigned ADDR_W = 21
) (
	input  wire logic              ref_clk_in,     // Controller clock
	input  wire logic              rst_b_in,       // Synchronous reset, active low
	input  wire logic              clk_en_in,      // Freezes state while low
	input  wire logic              start_in,       // One-cycle start pulse
	input  wire logic              write_in,       // High for a write cycle
	input  wire logic [ADDR_W-1:0] addr_in,        // Cycle address
	input  wire logic [7:0]        data_in,        // Write data
	input  wire logic [7:0]        sync_data_in,   // Synchronised data lines
	output logic                   done_out,       // One-cycle end pulse
	output logic      [7:0]        rdata_out,      // Captured read data
	output logic      [ADDR_W-1:0] flash_addr_out, // Address pins
	output logic      [7:0]        dq_out,         // Data lines driven value
	output logic                   dq_oe_out,      // Data lines enable
	output logic                   ce_b_out,       // Chip select, active low
	output logic                   oe_b_out,       // Output enable, active low
	output logic                   we_b_out        // Write strobe, active low
);
	typedef enum logic [3:0] {
		E_IDLE    = 4'h1,
		E_SETUP   = 4'h2,
		E_ACTIVE  = 4'h4,
		E_RECOVER = 4'h8
	} eng_state_e;

	eng_state_e state_q;
	logic [3:0] cnt_q;
	logic       write_q;

	// Output enable is never low while the write strobe is low, and every strobe
	// stays low for whole cycles, far longer than any noise pulse.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
		begin
			state_q        <= E_IDLE;
			cnt_q          <= 4'h0;
			write_q        <= 1'b0;
			done_out       <= 1'b0;
			rdata_out      <= 8'h00;
			flash_addr_out <= '0;
			dq_out         <= 8'h00;
			dq_oe_out      <= 1'b0;
			ce_b_out       <= 1'b1;
			oe_b_out       <= 1'b1;
			we_b_out       <= 1'b1;
		end
		else if (clk_en_in)
		begin
			done_out <= 1'b0;
			unique case (state_q)
				E_IDLE:
				begin
					if (start_in)
					begin
						write_q        <= write_in;
						flash_addr_out <= addr_in;
						dq_out         <= data_in;
						dq_oe_out      <= write_in;
						ce_b_out       <= 1'b0;
						state_q        <= E_SETUP;
					end
				end
				E_SETUP:
				begin
					if (write_q)
					begin
						we_b_out <= 1'b0;
						cnt_q    <= flash_host_pkg::WE_CNT;
					end
					else
					begin
						oe_b_out <= 1'b0;
						cnt_q    <= flash_host_pkg::READ_CNT;
					end
					state_q <= E_ACTIVE;
				end
				E_ACTIVE:
				begin
					if (cnt_q != 4'h0)
						cnt_q <= cnt_q - 4'h1;
					else
					begin
						if (!write_q)
							rdata_out <= sync_data_in;
						we_b_out <= 1'b1;
						oe_b_out <= 1'b1;
						ce_b_out <= 1'b1;
						cnt_q    <= flash_host_pkg::RECOVER_CNT;
						state_q  <= E_RECOVER;
					end
				end
				E_RECOVER:
				begin
					// Data are held past the strobe rise for hold time
					if (cnt_q != 4'h0)
						cnt_q <= cnt_q - 4'h1;
					else
					begin
						dq_oe_out <= 1'b0;
						done_out  <= 1'b1;
						state_q   <= E_IDLE;
					end
				end
				default: state_q <= E_IDLE;
			endcase
		end
	end

	strobe_inhibit_a: assert property (
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!we_b_out |-> (!ce_b_out && oe_b_out && dq_oe_out))
		else $error("write strobe low without chip select or with output enable");
endmodule : flash_cycle_engine
`default_nettype wire

// ---- verification/flash_dev_model.sv ----
// Behavioural flash device that answers the host controller's cycles.
// Assumes the bench sets busy_n, arm, fail, win, prog and susp by hierarchical reference.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
	input  wire logic        ce_b_in,  // Chip select, active low
	input  wire logic        oe_b_in,  // Output enable, active low
	input  wire logic        we_b_in,  // Write strobe, active low
	input  wire logic [20:0] addr_in,  // Address pins
	input  wire logic [7:0]  dq_in,    // Data lines level
	output logic      [7:0]  dq_out,   // Value driven on reads
	output logic             ready_out // Ready/busy, high when ready
);
	int          busy_n = 0;
	int          bad = 0;
	logic        fail = 1'b0;
	logic        win = 1'b1;
	logic        tog = 1'b0;
	logic [7:0]  arr = 8'h5A;
	logic [7:0]  last = 8'h00;
	logic [7:0]  wcmd = 8'h00;
	logic [20:0] waddr = '0;
	realtime     t_fall = 0;
	int          arm = 0;
	logic        prog = 1'b0;
	logic        susp = 1'b0;
	logic        stog = 1'b0;
	logic [4:0]  esec = 5'h00;
	initial dq_out = 8'hFF;
	// The sector toggle moves only for reads inside the erase sector, address bits 20:16
	always @(negedge oe_b_in)
	begin
		if (!ce_b_in && susp && addr_in[20:16] == esec)
		begin
			stog = ~stog;
			last = {1'b1, tog, 1'b0, 1'b0, 1'b0, stog, 2'h0};
		end
		else if (!ce_b_in && (busy_n > 0 || fail))
		begin
			tog = ~tog;
			if (!fail)
				busy_n--;
			if (addr_in[20:16] == esec)
				stog = ~stog;
			if (prog)
				last = {~wcmd[7], tog, fail, 5'h00};
			else
				last = {1'b0, tog, fail, 1'b0, win, stog, 2'h0};
			// A program cannot lift stored zeros and raises no timeout for trying
			if (prog && busy_n == 0)
				arr = arr & wcmd;
		end
		else
			last = arr;
		dq_out = last;
	end
	// Released lines show the inverse so a stale value cannot pass
	always @(posedge oe_b_in)
		dq_out = ~last;
	always @(negedge we_b_in)
	begin
		t_fall = $realtime;
		if (!oe_b_in || ce_b_in)
			bad++;
	end
	always @(posedge we_b_in)
	begin
		if ($realtime - t_fall >= 5.0 && oe_b_in)
		begin
			wcmd = dq_in;
			waddr = addr_in;
			if (dq_in == 8'hF0)
				fail = 1'b0;
			else if (arm > 0)
			begin
				busy_n = arm;
				arm = 0;
			end
		end
	end
	assign ready_out = !(busy_n > 0 || fail);
endmodule : flash_dev_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the flash status host controller.
// Assumes the device model stands on the flash pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        ref_clk_in;
	logic        rst_b_in;
	logic [7:0]  reg_addr_in;
	logic [31:0] reg_wdata_in;
	logic        reg_wr_in;
	logic        reg_rd_in;
	logic [31:0] reg_rdata_out;
	logic [20:0] flash_addr;
	logic [7:0]  dq_drv;
	logic        dq_oe;
	logic        ce_b;
	logic        oe_b;
	logic        we_b;
	logic        ready;
	logic        hv;
	logic [7:0]  dev_dq;
	logic        clk_en;
	logic        frst_b;
	wire  [7:0]  dq_bus = dq_oe ? dq_drv : dev_dq;
	int          fails = 0;
	int          comparisons = 0;
	logic [31:0] s;
	flash_status_host DUT (
		.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .flash_addr_out(flash_addr),
		.dq_in(dq_bus), .dq_out(dq_drv), .dq_oe_out(dq_oe), .ce_b_out(ce_b),
		.oe_b_out(oe_b), .we_b_out(we_b), .ready_busy_in(ready),
		.flash_reset_b_out(frst_b), .hv_unprotect_out(hv));
	flash_dev_model dev (
		.ce_b_in(ce_b), .oe_b_in(oe_b), .we_b_in(we_b), .addr_in(flash_addr),
		.dq_in(dq_bus), .dq_out(dev_dq), .ready_out(ready));
	initial
	begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	task automatic summarize();
		if (fails == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		s = reg_rdata_out;
	endtask : rd
	// Orders an operation and polls status until done, within a bound
	task automatic run(input logic [2:0] op);
		int i;
		wr(flash_host_pkg::REG_ORDER, {29'h0, op});
		for (i = 0; i < 400; i++)
		begin
			rd(flash_host_pkg::REG_STATUS);
			if (s[flash_host_pkg::ST_DONE] === 1'b1 && s[flash_host_pkg::ST_BUSY] === 1'b0)
				return;
		end
		fails++;
		summarize();
	endtask : run
	initial
	begin
		int w;
		rst_b_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 32'h0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		clk_en = 1'b1;
		repeat (5) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		rd(8'h20);
		chk("unmapped", 32'h0, s);
		rd(flash_host_pkg::REG_STATUS);
		chk("ready_pin", 32'h1, 32'(s[flash_host_pkg::ST_READY]));
		chk("flash_reset", 32'h1, 32'(frst_b));
		wr(flash_host_pkg::REG_UNPROT, 32'h1);
		chk("hv_on", 32'h1, 32'(hv));
		wr(flash_host_pkg::REG_UNPROT, 32'h0);
		chk("hv_off", 32'h0, 32'(hv));
		@(posedge ref_clk_in);
		clk_en <= 1'b0;
		wr(flash_host_pkg::REG_UNPROT, 32'h1);
		chk("hv_frozen", 32'h0, 32'(hv));
		@(posedge ref_clk_in);
		clk_en <= 1'b1;
		wr(flash_host_pkg::REG_ADDR, 32'h01234);
		wr(flash_host_pkg::REG_WDATA, 32'hA5);
		run(flash_host_pkg::OP_WRITE);
		chk("wdata", 32'hA5, 32'(dev.wcmd));
		chk("waddr", 32'h01234, 32'(dev.waddr));
		run(flash_host_pkg::OP_READ);
		chk("array", 32'h5A, 32'(s[15:8]));
		dev.busy_n = 5;
		run(flash_host_pkg::OP_POLL);
		chk("poll_fail", 32'h0, 32'(s[flash_host_pkg::ST_FAIL]));
		chk("poll_ready", 32'h1, 32'(s[flash_host_pkg::ST_READY]));
		chk("reads_left", 32'h0, 32'(dev.busy_n));
		dev.fail = 1'b1;
		run(flash_host_pkg::OP_POLL);
		chk("timeout", 32'h1, 32'(s[flash_host_pkg::ST_FAIL]));
		chk("reset_cmd", 32'hF0, 32'(dev.wcmd));
		run(flash_host_pkg::OP_READ);
		chk("after_reset", 32'h5A, 32'(s[15:8]));
		for (w = 0; w < 2; w++)
		begin
			dev.win = w[0];
			dev.busy_n = 9;
			run(flash_host_pkg::OP_ADD_SECTOR);
			chk("reject", 32'(w), 32'(s[flash_host_pkg::ST_REJECT]));
		end
		dev.busy_n = 0;
		dev.susp = 1'b1;
		run(flash_host_pkg::OP_READ);
		chk("susp_poll", 32'h1, 32'(s[15]));
		chk("susp_ready", 32'h1, 32'(s[flash_host_pkg::ST_READY]));
		w = int'(s[10]);
		run(flash_host_pkg::OP_READ);
		chk("susp_toggle", 32'(w[0] ^ 1'b1), 32'(s[10]));
		wr(flash_host_pkg::REG_ADDR, 32'h10000);
		run(flash_host_pkg::OP_READ);
		chk("susp_other", 32'h5A, 32'(s[15:8]));
		dev.susp = 1'b0;
		dev.busy_n = 20;
		wr(flash_host_pkg::REG_ORDER, {29'h0, flash_host_pkg::OP_POLL});
		wr(flash_host_pkg::REG_ORDER, {29'h0, flash_host_pkg::OP_ABORT});
		s = 32'hFFFF_FFFF;
		for (w = 0; w < 50 && s[flash_host_pkg::ST_BUSY] !== 1'b0; w++)
			rd(flash_host_pkg::REG_STATUS);
		chk("abort_idle", 32'h0, 32'(s[flash_host_pkg::ST_BUSY]));
		chk("abort_done", 32'h0, 32'(s[flash_host_pkg::ST_DONE]));
		run(flash_host_pkg::OP_POLL);
		chk("resumed", 32'h0, 32'(dev.busy_n));
		wr(flash_host_pkg::REG_WDATA, 32'h0F);
		dev.prog = 1'b1;
		dev.arm = 4;
		run(flash_host_pkg::OP_WRITE);
		run(flash_host_pkg::OP_READ);
		chk("prog_poll", 32'h1, 32'(s[15]));
		chk("prog_sector", 32'h0, 32'(s[10]));
		chk("prog_busy", 32'h0, 32'(s[flash_host_pkg::ST_READY]));
		run(flash_host_pkg::OP_POLL);
		chk("prog_timeout", 32'h0, 32'(s[flash_host_pkg::ST_FAIL]));
		run(flash_host_pkg::OP_READ);
		chk("programmed", 32'h0A, 32'(s[15:8]));
		dev.prog = 1'b0;
		wr(flash_host_pkg::REG_UNPROT, 32'h1);
		@(posedge ref_clk_in);
		rst_b_in <= 1'b0;
		@(posedge ref_clk_in);
		#1;
		chk("hv_reset", 32'h0, 32'(hv));
		chk("flash_reset_low", 32'h0, 32'(frst_b));
		@(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		run(flash_host_pkg::OP_READ);
		chk("flash_reset_high", 32'h1, 32'(frst_b));
		chk("reset_read", 32'h0A, 32'(s[15:8]));
		chk("strobes", 32'h0, 32'(dev.bad));
		summarize();
	end
endmodule : tb
`default_nettype wire
